// file: src/cmsr_cfg.svh
// Offsets, field positions, reset values and timing for the clock and mute register bank
`ifndef CMSR_CFG_SVH
`define CMSR_CFG_SVH
`define CMSR_DEV_ADDR 7'h4d
`define CMSR_OFS_PAGE 8'h00
`define CMSR_PAGE_MAIN 8'h00
`define CMSR_PAGE_ANALOG 8'h01
`define CMSR_OFS_AMP_REF 8'h01
`define CMSR_OFS_GAIN 8'h02
`define CMSR_OFS_FAULT 8'h5f
`define CMSR_OFS_MUTE_MON 8'h6c
`define CMSR_OFS_PIN_LEVEL 8'h77
`define CMSR_OFS_AUTO_MUTE 8'h78
`define CMSR_BIT_HALT 4
`define CMSR_BIT_ABSENT 2
`define CMSR_BIT_RESYNC 1
`define CMSR_BIT_CLK_ERR 0
`define CMSR_BIT_LEFT_MUTE 1
`define CMSR_BIT_RIGHT_MUTE 0
`define CMSR_BIT_PIN_TWO 5
`define CMSR_BIT_MUTE_PIN 4
`define CMSR_BIT_PIN_ZERO 3
`define CMSR_BIT_LEFT_AUTO 4
`define CMSR_BIT_RIGHT_AUTO 0
`define CMSR_BIT_AMP_REF 0
`define CMSR_BIT_LEFT_GAIN 4
`define CMSR_BIT_RIGHT_GAIN 0
`define CMSR_RST_AMP_REF 1'h0
`define CMSR_RST_GAIN 1'h0
`define CMSR_RST_PAGE 8'h00
`define CMSR_SYNC_STAGES 2
`endif

// file: src/cmsr_pkg.sv
// Types for the clock and mute register bank
package cmsr_pkg;
    typedef enum logic [3:0] {
        CMSR_IDLE,
        CMSR_ADDR,
        CMSR_ADDR_ACK,
        CMSR_PTR,
        CMSR_PTR_ACK,
        CMSR_WR,
        CMSR_WR_ACK,
        CMSR_RD,
        CMSR_RD_ACK
    } cmsr_link_state_t;
endpackage

// file: src/cmsr_sync.sv
// Two-stage synchroniser for signals from outside the core clock domain
`timescale 1ns/1ps
module cmsr_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // cmsr_sync

// file: src/cmsr_regs.sv
// Clock fault, mute and analog control registers behind a two-wire control port
`timescale 1ns/1ps
`include "cmsr_cfg.svh"
// Contract
// - Master clock halt latches; read clears it
// - Clock error latches; read clears it
// - Absent bit set only when both clocks low
// - Resync bit follows resynchronisation in progress
// - Analog mute monitor, left bit1, right bit0
// - Live levels of pin two, mute, zero
// - Auto-mute flags, left bit4, right bit0
// - Amplitude reference select, reset constant amplitude
// - Analog gain bits, 0 dB or -6 dB
module cmsr_regs #(
    parameter logic [6:0] DEV_ADDR = `CMSR_DEV_ADDR
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic master_clock_halt_event,
    input wire logic clock_error_event,
    input wire logic frame_bit_clocks_absent,
    input wire logic clock_resync_active,
    input wire logic left_analog_mute_state,
    input wire logic right_analog_mute_state,
    input wire logic general_pin_two,
    input wire logic mute_pin,
    input wire logic general_pin_zero,
    input wire logic left_auto_mute_flag,
    input wire logic right_auto_mute_flag,
    output logic amplitude_reference_select,
    output logic left_analog_gain,
    output logic right_analog_gain
);
    logic [4:0] pins_s;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [7:0] page;
    logic rw;
    logic nack;
    logic latched_master_clock_halt;
    logic latched_clock_error;
    cmsr_pkg::cmsr_link_state_t st;

    // Pins from outside the core clock domain
    cmsr_sync #(.W(5)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .d({scl, sda_in, general_pin_two, mute_pin, general_pin_zero}),
        .q(pins_s)
    );

    wire scl_s = pins_s[4];
    wire sda_s = pins_s[3];
    wire general_pin_two_level = pins_s[2];
    wire mute_pin_level = pins_s[1];
    wire general_pin_zero_level = pins_s[0];

    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;
    wire byte_done = (cnt == 4'h8);
    wire addr_match = (shreg[7:1] == DEV_ADDR);

    // Address decode
    wire on_main = (page == `CMSR_PAGE_MAIN);
    wire on_analog = (page == `CMSR_PAGE_ANALOG);
    wire sel_page = (ptr == `CMSR_OFS_PAGE);
    wire sel_fault = on_main & (ptr == `CMSR_OFS_FAULT);
    wire sel_mute_mon = on_main & (ptr == `CMSR_OFS_MUTE_MON);
    wire sel_pin_level = on_main & (ptr == `CMSR_OFS_PIN_LEVEL);
    wire sel_auto_mute = on_main & (ptr == `CMSR_OFS_AUTO_MUTE);
    wire sel_amp_ref = on_analog & (ptr == `CMSR_OFS_AMP_REF);
    wire sel_gain = on_analog & (ptr == `CMSR_OFS_GAIN);

    logic [7:0] fault_word;
    logic [7:0] mute_word;
    logic [7:0] pin_word;
    logic [7:0] auto_word;
    logic [7:0] amp_word;
    logic [7:0] gain_word;
    always_comb begin
        fault_word = 8'h00;
        fault_word[`CMSR_BIT_HALT] = latched_master_clock_halt;
        fault_word[`CMSR_BIT_ABSENT] = frame_bit_clocks_absent;
        fault_word[`CMSR_BIT_RESYNC] = clock_resync_active;
        fault_word[`CMSR_BIT_CLK_ERR] = latched_clock_error;
        mute_word = 8'h00;
        mute_word[`CMSR_BIT_LEFT_MUTE] = left_analog_mute_state;
        mute_word[`CMSR_BIT_RIGHT_MUTE] = right_analog_mute_state;
        pin_word = 8'h00;
        pin_word[`CMSR_BIT_PIN_TWO] = general_pin_two_level;
        pin_word[`CMSR_BIT_MUTE_PIN] = mute_pin_level;
        pin_word[`CMSR_BIT_PIN_ZERO] = general_pin_zero_level;
        auto_word = 8'h00;
        auto_word[`CMSR_BIT_LEFT_AUTO] = left_auto_mute_flag;
        auto_word[`CMSR_BIT_RIGHT_AUTO] = right_auto_mute_flag;
        amp_word = 8'h00;
        amp_word[`CMSR_BIT_AMP_REF] = amplitude_reference_select;
        gain_word = 8'h00;
        gain_word[`CMSR_BIT_LEFT_GAIN] = left_analog_gain;
        gain_word[`CMSR_BIT_RIGHT_GAIN] = right_analog_gain;
    end

    wire [7:0] rd_data = sel_page ? page :
                         sel_fault ? fault_word :
                         sel_mute_mon ? mute_word :
                         sel_pin_level ? pin_word :
                         sel_auto_mute ? auto_word :
                         sel_amp_ref ? amp_word :
                         sel_gain ? gain_word : 8'h00;

    // Byte loads for reads and the write strobe
    wire in_addr_ack = (st == cmsr_pkg::CMSR_ADDR_ACK);
    wire in_rd_ack = (st == cmsr_pkg::CMSR_RD_ACK);
    wire read_load = scl_fall & ((in_addr_ack & rw) | (in_rd_ack & ~nack));
    wire wr_strobe = scl_fall & (st == cmsr_pkg::CMSR_WR) & byte_done;
    wire fault_clear = read_load & sel_fault;

    // Latched fault bits, set wins over the clearing read
    wire next_halt = master_clock_halt_event | (latched_master_clock_halt & ~fault_clear);
    wire next_err = clock_error_event | (latched_clock_error & ~fault_clear);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            latched_master_clock_halt <= 1'h0;
            latched_clock_error <= 1'h0;
        end else begin
            latched_master_clock_halt <= next_halt;
            latched_clock_error <= next_err;
        end
    end

    // Writable registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            page <= `CMSR_RST_PAGE;
            amplitude_reference_select <= `CMSR_RST_AMP_REF;
            left_analog_gain <= `CMSR_RST_GAIN;
            right_analog_gain <= `CMSR_RST_GAIN;
        end else if (wr_strobe) begin
            if (sel_page) begin
                page <= shreg;
            end else if (sel_amp_ref) begin
                amplitude_reference_select <= shreg[`CMSR_BIT_AMP_REF];
            end else if (sel_gain) begin
                left_analog_gain <= shreg[`CMSR_BIT_LEFT_GAIN];
                right_analog_gain <= shreg[`CMSR_BIT_RIGHT_GAIN];
            end
        end
    end

    // Control port engine
    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
            st <= cmsr_pkg::CMSR_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'h0;
            nack <= 1'h0;
            sda_out <= 1'h0;
            sda_oe <= 1'h0;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            sda_out <= 1'h0;
            if (start_cond) begin
                st <= cmsr_pkg::CMSR_ADDR;
                cnt <= 4'h0;
                sda_oe <= 1'h0;
            end else if (stop_cond) begin
                st <= cmsr_pkg::CMSR_IDLE;
                sda_oe <= 1'h0;
            end else if (scl_rise) begin
                case (st)
                    cmsr_pkg::CMSR_ADDR, cmsr_pkg::CMSR_PTR, cmsr_pkg::CMSR_WR: begin
                        shreg <= {shreg[6:0], sda_s};
                        cnt <= cnt + 4'h1;
                    end
                    cmsr_pkg::CMSR_RD: cnt <= cnt + 4'h1;
                    cmsr_pkg::CMSR_RD_ACK: nack <= sda_s;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (st)
                    cmsr_pkg::CMSR_ADDR: begin
                        if (byte_done) begin
                            rw <= shreg[0];
                            sda_oe <= addr_match;
                            st <= addr_match ? cmsr_pkg::CMSR_ADDR_ACK : cmsr_pkg::CMSR_IDLE;
                        end
                    end
                    cmsr_pkg::CMSR_PTR: begin
                        if (byte_done) begin
                            ptr <= shreg;
                            sda_oe <= 1'h1;
                            st <= cmsr_pkg::CMSR_PTR_ACK;
                        end
                    end
                    cmsr_pkg::CMSR_WR: begin
                        if (byte_done) begin
                            ptr <= ptr + 8'h01;
                            sda_oe <= 1'h1;
                            st <= cmsr_pkg::CMSR_WR_ACK;
                        end
                    end
                    cmsr_pkg::CMSR_RD: begin
                        if (byte_done) begin
                            sda_oe <= 1'h0;
                            st <= cmsr_pkg::CMSR_RD_ACK;
                        end else begin
                            shreg <= {shreg[6:0], 1'h0};
                            sda_oe <= ~shreg[6];
                        end
                    end
                    cmsr_pkg::CMSR_ADDR_ACK, cmsr_pkg::CMSR_RD_ACK: begin
                        cnt <= 4'h0;
                        if (read_load) begin
                            shreg <= rd_data;
                            sda_oe <= ~rd_data[7];
                            ptr <= ptr + 8'h01;
                            st <= cmsr_pkg::CMSR_RD;
                        end else begin
                            sda_oe <= 1'h0;
                            st <= in_addr_ack ? cmsr_pkg::CMSR_PTR : cmsr_pkg::CMSR_IDLE;
                        end
                    end
                    cmsr_pkg::CMSR_PTR_ACK, cmsr_pkg::CMSR_WR_ACK: begin
                        cnt <= 4'h0;
                        sda_oe <= 1'h0;
                        st <= cmsr_pkg::CMSR_WR;
                    end
                    default: ;
                endcase
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence addr_byte_seen;
        (st == cmsr_pkg::CMSR_ADDR) && byte_done && scl_fall && addr_match;
    endsequence
    sequence ack_driven;
        sda_oe && (st == cmsr_pkg::CMSR_ADDR_ACK);
    endsequence
    addr_ack_a: assert property (addr_byte_seen |=> ack_driven)
        else $error("address match not acknowledged");

    halt_set_a: assert property (master_clock_halt_event |=> latched_master_clock_halt)
        else $error("halt event not latched");
    halt_clear_a: assert property (fault_clear && !master_clock_halt_event |=> !latched_master_clock_halt)
        else $error("halt latch not cleared by read");
    err_hold_a: assert property (latched_clock_error && !fault_clear |=> latched_clock_error)
        else $error("clock error latch dropped without read");
    err_clear_a: assert property (fault_clear && !clock_error_event |=> !latched_clock_error)
        else $error("clock error latch not cleared by read");
    race_keep_a: assert property (fault_clear && clock_error_event && master_clock_halt_event
        |=> latched_clock_error && latched_master_clock_halt)
        else $error("event lost during clearing read");
    absent_bit_a: assert property (sel_fault |-> rd_data[`CMSR_BIT_ABSENT] == frame_bit_clocks_absent
        && rd_data[`CMSR_BIT_RESYNC] == clock_resync_active)
        else $error("absent or resync bit wrong");
    mute_map_a: assert property (sel_mute_mon |-> rd_data == {6'h00, left_analog_mute_state,
        right_analog_mute_state})
        else $error("mute monitor mapping wrong");
    pin_level_a: assert property (sel_pin_level && $stable(ptr) && $stable(page)
        |-> rd_data[`CMSR_BIT_PIN_TWO] == $past(general_pin_two, 2))
        else $error("pin level not reflected");
    auto_mute_a: assert property (sel_auto_mute |-> rd_data[`CMSR_BIT_LEFT_AUTO] == left_auto_mute_flag
        && rd_data[`CMSR_BIT_RIGHT_AUTO] == right_auto_mute_flag && rd_data[3:1] == 3'h0)
        else $error("auto mute flags wrong");
    amp_ref_a: assert property (wr_strobe && sel_amp_ref
        |=> amplitude_reference_select == $past(shreg[`CMSR_BIT_AMP_REF]))
        else $error("amplitude reference not written");
    gain_a: assert property (wr_strobe && sel_gain |=> left_analog_gain == $past(shreg[4])
        && right_analog_gain == $past(shreg[0]))
        else $error("analog gain not written");
endmodule // cmsr_regs

// file: test/cmsr_host.sv
// Host controller model for the two-wire control port
`timescale 1ns/1ps
module cmsr_host (
    input wire logic core_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    logic ack;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        ack = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // One clock bit, data held around the whole high phase
    task automatic bitx(input logic b, output logic s);
        tick(2);
        sda_low = ~b;
        tick(2);
        scl = 1'b1;
        tick(2);
        s = sda;
        tick(2);
        scl = 1'b0;
    endtask
    task automatic start();
        tick(2);
        sda_low = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(2);
        sda_low = 1'b1;
        tick(2);
        scl = 1'b0;
    endtask
    // Clock parks high between frames
    task automatic stop();
        tick(2);
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(2);
        sda_low = 1'b0;
        tick(4);
    endtask
    task automatic wbyte(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], s);
        end
        bitx(1'b1, ack);
    endtask
    // One read byte; the last one is not acknowledged
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(last, s);
    endtask
endmodule // cmsr_host

// file: test/tb_top.sv
// Self-checking bench for the clock and mute register bank
`timescale 1ns/1ps
`include "cmsr_cfg.svh"
module tb_top;
    logic core_clk, rst, scl, sda_low, sda, sda_out, sda_oe;
    logic halt_ev, err_ev, absent, resync, l_mute, r_mute, pin_two, mute_pin, pin_zero, l_auto, r_auto;
    logic amp_sel, l_gain, r_gain;
    int error_cnt, n_tests;
    assign sda = (sda_oe | sda_low) ? 1'b0 : 1'b1;
    cmsr_regs i_cmsr_regs (.core_clk(core_clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .master_clock_halt_event(halt_ev), .clock_error_event(err_ev),
        .frame_bit_clocks_absent(absent), .clock_resync_active(resync), .left_analog_mute_state(l_mute),
        .right_analog_mute_state(r_mute), .general_pin_two(pin_two), .mute_pin(mute_pin),
        .general_pin_zero(pin_zero), .left_auto_mute_flag(l_auto), .right_auto_mute_flag(r_auto),
        .amplitude_reference_select(amp_sel), .left_analog_gain(l_gain), .right_analog_gain(r_gain));
    cmsr_host i_cmsr_host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        i_cmsr_host.start();
        i_cmsr_host.wbyte({`CMSR_DEV_ADDR, 1'b0});
        i_cmsr_host.wbyte(ofs);
        i_cmsr_host.wbyte(d);
        i_cmsr_host.stop();
    endtask
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp, input string name);
        logic [7:0] d;
        i_cmsr_host.start();
        i_cmsr_host.wbyte({`CMSR_DEV_ADDR, 1'b0});
        i_cmsr_host.wbyte(ofs);
        i_cmsr_host.start();
        i_cmsr_host.wbyte({`CMSR_DEV_ADDR, 1'b1});
        i_cmsr_host.rbyte(1'b1, d);
        i_cmsr_host.stop();
        chk(name, exp, d);
    endtask
    task automatic chk_out(input logic [7:0] exp);
        chk("analog_outputs", exp, {4'h0, sda_out, amp_sel, l_gain, r_gain});
    endtask
    task automatic t_reset();
        chk_out(8'h00);
        wr(8'h00, 8'h01);
        rd(8'h01, 8'h00, "amp_ref_reset");
        rd(8'h02, 8'h00, "gain_reset");
    endtask
    task automatic t_analog();
        wr(8'h01, 8'hff);
        rd(8'h01, 8'h01, "amp_ref");
        chk_out(8'h04);
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h11, "gain");
        chk_out(8'h07);
        wr(8'h02, 8'h10);
        chk_out(8'h06);
        wr(8'h02, 8'h01);
        chk_out(8'h05);
        wr(8'h01, 8'h00);
        chk_out(8'h01);
        wr(8'h00, 8'h00);
    endtask
    task automatic t_latch();
        @(negedge core_clk);
        halt_ev = 1'b1;
        @(negedge core_clk);
        halt_ev = 1'b0;
        rd(8'h5f, 8'h10, "halt_set");
        rd(8'h5f, 8'h00, "halt_clear");
        @(negedge core_clk);
        err_ev = 1'b1;
        @(negedge core_clk);
        err_ev = 1'b0;
        rd(8'h5f, 8'h01, "error_set");
        rd(8'h5f, 8'h00, "error_clear");
    endtask
    task automatic t_levels();
        logic v;
        for (int i = 0; i < 2; i++) begin
            v = i[0];
            {absent, l_mute, pin_two, pin_zero, l_auto} = {5{v}};
            {resync, r_mute, mute_pin, r_auto} = {4{~v}};
            wr(8'h6c, 8'hff);
            rd(8'h5f, v ? 8'h04 : 8'h02, "clock_status");
            rd(8'h6c, v ? 8'h02 : 8'h01, "mute_monitor");
            rd(8'h77, v ? 8'h28 : 8'h10, "pin_levels");
            rd(8'h78, v ? 8'h10 : 8'h01, "auto_mute");
        end
    endtask
    task automatic t_refuse();
        i_cmsr_host.start();
        i_cmsr_host.wbyte({`CMSR_DEV_ADDR ^ 7'h01, 1'b0});
        chk("foreign_address_ack", 8'h01, {7'h00, i_cmsr_host.ack});
        i_cmsr_host.stop();
        rd(8'h10, 8'h00, "unmapped_read");
    endtask
    // Events kept high across the clearing read must survive it
    task automatic t_hold();
        @(negedge core_clk);
        {halt_ev, err_ev} = 2'b11;
        rd(8'h5f, 8'h15, "events_during_read");
        {halt_ev, err_ev} = 2'b00;
        rd(8'h5f, 8'h15, "events_kept");
        rd(8'h5f, 8'h04, "events_cleared");
    endtask
    // Burst write through the page select, burst read with host ack
    task automatic t_burst();
        logic [7:0] d0;
        logic [7:0] d1;
        i_cmsr_host.start();
        i_cmsr_host.wbyte({`CMSR_DEV_ADDR, 1'b0});
        i_cmsr_host.wbyte(8'h00);
        i_cmsr_host.wbyte(8'h01);
        i_cmsr_host.wbyte(8'h01);
        i_cmsr_host.wbyte(8'h10);
        i_cmsr_host.stop();
        chk_out(8'h06);
        i_cmsr_host.start();
        i_cmsr_host.wbyte({`CMSR_DEV_ADDR, 1'b0});
        i_cmsr_host.wbyte(8'h01);
        i_cmsr_host.start();
        i_cmsr_host.wbyte({`CMSR_DEV_ADDR, 1'b1});
        i_cmsr_host.rbyte(1'b0, d0);
        i_cmsr_host.rbyte(1'b1, d1);
        i_cmsr_host.stop();
        chk("burst_amp_ref", 8'h01, d0);
        chk("burst_gain", 8'h10, d1);
    endtask
    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        {halt_ev, err_ev, absent, resync, l_mute, r_mute} = 6'h00;
        {pin_two, mute_pin, pin_zero, l_auto, r_auto} = 5'h00;
        rst = 1'b1;
        error_cnt = 0;
        n_tests = 0;
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        t_reset();
        t_analog();
        t_latch();
        t_levels();
        t_refuse();
        t_hold();
        t_burst();
        summarize();
    end
    // Whole run takes about 9300 cycles
    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        summarize();
    end
endmodule // tb_top
